// *** include/dacref_pkg.sv ***
package dacref_pkg;

  // ==========================================================================
  // Register map (word index on the plain port)
  localparam logic [1:0] ADDR_CTRL0   = 2'h0;
  localparam logic [1:0] ADDR_LEVEL   = 2'h1;
  localparam logic [1:0] ADDR_STATUS  = 2'h2;

  // ==========================================================================
  // Control register 0 fields
  localparam int CTRL0_EN_BIT   = 7;
  localparam int CTRL0_LPS_BIT  = 6;
  localparam int CTRL0_OE_BIT   = 5;
  localparam int CTRL0_PSS_LSB  = 2;
  localparam int CTRL0_NSS_BIT  = 0;

  localparam int LEVEL_W        = 5;
  localparam int NUM_LEVELS     = 32;

  localparam logic [7:0] CTRL0_RESET  = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_ALL_ONES  = 5'h1F;
  localparam logic [LEVEL_W-1:0] LEVEL_ALL_ZEROS = 5'h00;

  // ==========================================================================
  // Positive source encodings
  localparam logic [1:0] PSS_SUPPLY  = 2'h0;
  localparam logic [1:0] PSS_EXT_REF = 2'h1;
  localparam logic [1:0] PSS_FIXED   = 2'h2;

  // One-hot source switch patterns towards the ladder
  localparam logic [2:0] POS_ONEHOT_SUPPLY  = 3'h1;
  localparam logic [2:0] POS_ONEHOT_EXT_REF = 3'h2;
  localparam logic [2:0] POS_ONEHOT_FIXED   = 3'h4;
  localparam logic [2:0] POS_ONEHOT_NONE    = 3'h0;

  // Unimplemented control bits read as zero
  localparam logic [7:0] CTRL0_READ_MASK = 8'hED;

  typedef enum logic [1:0] {
    DACREF_MODE_OFF,
    DACREF_MODE_LADDER,
    DACREF_MODE_CLAMP_POS,
    DACREF_MODE_CLAMP_NEG
  } dacref_mode_t;

  // Switch controls towards the analog ladder
  typedef struct packed {
    logic                 ladder_on;
    logic                 pos_connect;
    logic                 neg_connect;
    logic [2:0]           pos_sel_onehot;
    logic [NUM_LEVELS-1:0] tap_sel;
  } dacref_analog_t;

  // Reset register values select the negative clamp from the supply
  localparam dacref_analog_t ANALOG_RESET = '{
    ladder_on:      1'b0,
    pos_connect:    1'b0,
    neg_connect:    1'b1,
    pos_sel_onehot: POS_ONEHOT_SUPPLY,
    tap_sel:        32'h00000001
  };

endpackage : dacref_pkg

// *** rtl/dacref_tap_decode.sv ***
`timescale 1ns/100ps
module dacref_tap_decode (
  input  wire logic [dacref_pkg::LEVEL_W-1:0]    code,
  output logic      [dacref_pkg::NUM_LEVELS-1:0] taps
);

  // ==========================================================================
  // One-hot tap select
  genvar i;
  generate
    for (i = 0; i < dacref_pkg::NUM_LEVELS; i++)
    begin : g_tap
      localparam int unsigned TAP_IDX = i;
      assign taps[i] = (code == TAP_IDX[dacref_pkg::LEVEL_W-1:0]);
    end
  endgenerate

endmodule : dacref_tap_decode

// *** rtl/dacref_ctrl.sv ***
`timescale 1ns/100ps
module dacref_ctrl (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [1:0]                    addr,
  input  wire logic [7:0]                    wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [7:0]                    rdata,
  input  wire logic                          pin_digital_in,
  output logic                               pin_digital_read,
  output logic                               pin_analog_route,
  output logic                               pin_digital_drive_off,
  output dacref_pkg::dacref_analog_t         analog_r
);

  // ==========================================================================
  // Registers
  logic [7:0]                       ctrl0_r;
  logic [dacref_pkg::LEVEL_W-1:0]   level_r;
  dacref_pkg::dacref_mode_t         mode;
  logic [dacref_pkg::NUM_LEVELS-1:0] taps;
  dacref_pkg::dacref_analog_t       analog_nxt;
  logic                             en_nxt;
  logic                             lps_nxt;
  logic                             oe_nxt;
  logic [1:0]                       pss_nxt;
  logic [dacref_pkg::LEVEL_W-1:0]   level_nxt;
  logic [7:0]                       ctrl0_nxt;

  // No sleep input: only reset and port writes touch these, so wake is harmless
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl0_r <= dacref_pkg::CTRL0_RESET;
    else if (wr && addr == dacref_pkg::ADDR_CTRL0)
      ctrl0_r <= wdata;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      level_r <= dacref_pkg::LEVEL_RESET;
    else if (wr && addr == dacref_pkg::ADDR_LEVEL)
      level_r <= wdata[dacref_pkg::LEVEL_W-1:0];
  end

  // ==========================================================================
  // Next-cycle view so outputs change on the same edge that takes the write
  always_comb
  begin
    ctrl0_nxt = ctrl0_r;
    level_nxt = level_r;
    if (wr && addr == dacref_pkg::ADDR_CTRL0)
      ctrl0_nxt = wdata;
    if (wr && addr == dacref_pkg::ADDR_LEVEL)
      level_nxt = wdata[dacref_pkg::LEVEL_W-1:0];
  end

  assign en_nxt  = ctrl0_nxt[dacref_pkg::CTRL0_EN_BIT];
  assign lps_nxt = ctrl0_nxt[dacref_pkg::CTRL0_LPS_BIT];
  assign oe_nxt  = ctrl0_nxt[dacref_pkg::CTRL0_OE_BIT];
  assign pss_nxt = ctrl0_nxt[dacref_pkg::CTRL0_PSS_LSB +: 2];

  dacref_tap_decode u_taps (
    .code (level_nxt),
    .taps (taps)
  );

  // ==========================================================================
  // Mode selection
  always_comb
  begin
    if (en_nxt)
      mode = dacref_pkg::DACREF_MODE_LADDER;
    else if (lps_nxt && level_nxt == dacref_pkg::LEVEL_ALL_ONES)
      mode = dacref_pkg::DACREF_MODE_CLAMP_POS;
    else if (!lps_nxt && level_nxt == dacref_pkg::LEVEL_ALL_ZEROS)
      mode = dacref_pkg::DACREF_MODE_CLAMP_NEG;
    else
      mode = dacref_pkg::DACREF_MODE_OFF;
  end

  always_comb
  begin
    analog_nxt = '0;
    // Reserved code leaves every source switch open
    case (pss_nxt)
      dacref_pkg::PSS_SUPPLY:  analog_nxt.pos_sel_onehot = dacref_pkg::POS_ONEHOT_SUPPLY;
      dacref_pkg::PSS_EXT_REF: analog_nxt.pos_sel_onehot = dacref_pkg::POS_ONEHOT_EXT_REF;
      dacref_pkg::PSS_FIXED:   analog_nxt.pos_sel_onehot = dacref_pkg::POS_ONEHOT_FIXED;
      default:                 analog_nxt.pos_sel_onehot = dacref_pkg::POS_ONEHOT_NONE;
    endcase
    case (mode)
      dacref_pkg::DACREF_MODE_LADDER:
      begin
        // Tap position k gives Vneg + (Vpos-Vneg)*k/32
        analog_nxt.ladder_on   = 1'b1;
        analog_nxt.pos_connect = 1'b1;
        analog_nxt.neg_connect = 1'b1;
        analog_nxt.tap_sel     = taps;
      end
      dacref_pkg::DACREF_MODE_CLAMP_POS:
      begin
        analog_nxt.pos_connect = 1'b1;
        analog_nxt.tap_sel     = taps;
      end
      dacref_pkg::DACREF_MODE_CLAMP_NEG:
      begin
        analog_nxt.neg_connect = 1'b1;
        analog_nxt.tap_sel     = taps;
      end
      default:
      begin
        // Low-power: one reference always cut off
        analog_nxt.pos_connect = lps_nxt;
        analog_nxt.neg_connect = !lps_nxt;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      // Matches the clamp the reset registers select, so no glitch on release
      analog_r <= dacref_pkg::ANALOG_RESET;
    else
      analog_r <= analog_nxt;
  end

  // ==========================================================================
  // Output pin override
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_analog_route      <= 1'b0;
      pin_digital_drive_off <= 1'b0;
    end
    else
    begin
      pin_analog_route      <= oe_nxt;
      pin_digital_drive_off <= oe_nxt;
    end
  end

  // Input detector is off while routed, so the read is forced low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_digital_read <= 1'b0;
    else
      pin_digital_read <= oe_nxt ? 1'b0 : pin_digital_in;
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
    begin
      if (addr == dacref_pkg::ADDR_CTRL0)
        rdata <= ctrl0_r & dacref_pkg::CTRL0_READ_MASK;
      else if (addr == dacref_pkg::ADDR_LEVEL)
        rdata <= {3'h0, level_r};
      else if (addr == dacref_pkg::ADDR_STATUS)
        rdata <= {6'h00, analog_r.neg_connect, analog_r.pos_connect};
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end

  // ==========================================================================
  // Checks: ladder and clamps
  a_write_to_ladder: assert property (
    @(posedge clk) disable iff (rst)
    (wr && addr == dacref_pkg::ADDR_CTRL0 && wdata[dacref_pkg::CTRL0_EN_BIT])
    |=> analog_r.ladder_on)
  else
    $error("enable write did not start ladder");
  a_ladder_needs_en: assert property (
    @(posedge clk) disable iff (rst)
    analog_r.ladder_on
    |-> ctrl0_r[dacref_pkg::CTRL0_EN_BIT])
  else
    $error("ladder on while disabled");
  a_enabled_both_ends: assert property (
    @(posedge clk) disable iff (rst)
    ctrl0_r[dacref_pkg::CTRL0_EN_BIT]
    |-> (analog_r.ladder_on && analog_r.pos_connect && analog_r.neg_connect))
  else
    $error("enabled ladder not tied to both sources");
  a_tap_matches_code: assert property (
    @(posedge clk) disable iff (rst)
    analog_r.ladder_on
    |-> ($onehot(analog_r.tap_sel) && analog_r.tap_sel[level_r]))
  else
    $error("tap does not match level code");
  a_taps_one_hot: assert property (
    @(posedge clk) disable iff (rst)
    1'b1
    |-> $onehot0(analog_r.tap_sel))
  else
    $error("more than one tap selected");
  a_clamp_pos_path: assert property (
    @(posedge clk) disable iff (rst)
    (!ctrl0_r[dacref_pkg::CTRL0_EN_BIT] && ctrl0_r[dacref_pkg::CTRL0_LPS_BIT] && level_r == dacref_pkg::LEVEL_ALL_ONES)
    |-> (analog_r.pos_connect && !analog_r.neg_connect && analog_r.tap_sel[dacref_pkg::NUM_LEVELS-1]))
  else
    $error("positive clamp wrong");
  a_clamp_neg_path: assert property (
    @(posedge clk) disable iff (rst)
    (!ctrl0_r[dacref_pkg::CTRL0_EN_BIT] && !ctrl0_r[dacref_pkg::CTRL0_LPS_BIT] && level_r == dacref_pkg::LEVEL_ALL_ZEROS)
    |-> (analog_r.neg_connect && !analog_r.pos_connect && analog_r.tap_sel[0]))
  else
    $error("negative clamp wrong");
  a_lowpower_cut: assert property (
    @(posedge clk) disable iff (rst)
    !ctrl0_r[dacref_pkg::CTRL0_EN_BIT]
    |-> (analog_r.neg_connect != ctrl0_r[dacref_pkg::CTRL0_LPS_BIT]))
  else
    $error("low-power cut-off wrong");
  a_pos_sel_supply: assert property (
    @(posedge clk) disable iff (rst)
    (ctrl0_r[dacref_pkg::CTRL0_PSS_LSB +: 2] == dacref_pkg::PSS_SUPPLY)
    |-> (analog_r.pos_sel_onehot == dacref_pkg::POS_ONEHOT_SUPPLY))
  else
    $error("supply source not selected");
  a_pos_sel_fixed: assert property (
    @(posedge clk) disable iff (rst)
    (ctrl0_r[dacref_pkg::CTRL0_PSS_LSB +: 2] == dacref_pkg::PSS_FIXED)
    |-> (analog_r.pos_sel_onehot == dacref_pkg::POS_ONEHOT_FIXED))
  else
    $error("fixed buffer source not selected");

  // ==========================================================================
  // Checks: pin override
  a_pin_route_oe: assert property (
    @(posedge clk) disable iff (rst)
    1'b1
    |-> (pin_analog_route == ctrl0_r[dacref_pkg::CTRL0_OE_BIT] && pin_digital_drive_off == pin_analog_route))
  else
    $error("pin route does not follow enable");
  a_pin_reads_zero: assert property (
    @(posedge clk) disable iff (rst)
    pin_analog_route
    |-> !pin_digital_read)
  else
    $error("routed pin read not zero");
  a_pin_read_follow: assert property (
    @(posedge clk) disable iff (rst)
    (!$past(rst) && !pin_analog_route)
    |-> (pin_digital_read == $past(pin_digital_in)))
  else
    $error("unrouted pin read does not follow pin");

  // ==========================================================================
  // Checks: register port
  a_level_write_lat: assert property (
    @(posedge clk) disable iff (rst)
    (wr && addr == dacref_pkg::ADDR_LEVEL)
    |=> (level_r == $past(wdata[dacref_pkg::LEVEL_W-1:0])))
  else
    $error("level write not taken");
  a_ctrl_write_lat: assert property (
    @(posedge clk) disable iff (rst)
    (wr && addr == dacref_pkg::ADDR_CTRL0)
    |=> (ctrl0_r == $past(wdata)))
  else
    $error("control write not taken");
  a_level_read_back: assert property (
    @(posedge clk) disable iff (rst)
    (rd && addr == dacref_pkg::ADDR_LEVEL)
    |=> (rdata == 8'($past(level_r))))
  else
    $error("level read back wrong");
  a_reset_clears: assert property (
    @(posedge clk)
    (rst && $past(rst))
    |-> (ctrl0_r == dacref_pkg::CTRL0_RESET && level_r == dacref_pkg::LEVEL_RESET && !pin_analog_route))
  else
    $error("reset did not clear control state");

  // ==========================================================================
  // Scenario covers
  c_ladder: cover property (@(posedge clk) disable iff (rst) analog_r.ladder_on);
  c_clamp_pos: cover property (@(posedge clk) disable iff (rst) !analog_r.ladder_on && analog_r.tap_sel[31]);
  c_clamp_neg: cover property (@(posedge clk) disable iff (rst) !analog_r.ladder_on && analog_r.tap_sel[0]);
  c_routed: cover property (@(posedge clk) disable iff (rst) pin_analog_route);
  c_pos_fixed: cover property (@(posedge clk) disable iff (rst) analog_r.pos_sel_onehot == dacref_pkg::POS_ONEHOT_FIXED);

endmodule : dacref_ctrl

// *** dv/dacref_ladder_model.sv ***
`timescale 1ns/100ps
// ====
// Ladder and pin model, output in 32nds of the source span
module dacref_ladder_model (
  input  wire logic                       clk,
  input  wire logic                       pin_route,
  input  wire logic                       ext_level,
  input  wire dacref_pkg::dacref_analog_t analog_r,
  output logic                            pin_level,
  output logic [7:0]                      vout
);
  logic toggle_r = 1'b0;

  always @(posedge clk)
    toggle_r <= ~toggle_r;

  // Released pad wanders so a stale level cannot fake a zero read
  assign pin_level = pin_route ? toggle_r : ext_level;

  // 8'hFF marks no defined output
  always_comb
  begin
    vout = 8'hFF;
    if (analog_r.ladder_on)
    begin
      for (int k = 0; k < dacref_pkg::NUM_LEVELS; k++)
        if (analog_r.tap_sel[k])
          vout = 8'(k);
    end
    else if (analog_r.pos_connect && !analog_r.neg_connect && analog_r.tap_sel[31])
      vout = 8'h20;
    else if (analog_r.neg_connect && !analog_r.pos_connect && analog_r.tap_sel[0])
      vout = 8'h00;
  end
endmodule : dacref_ladder_model

// *** dv/dacref_ctrl_bench.sv ***
`timescale 1ns/100ps
module dacref_ctrl_bench;
  logic                       clk;
  logic                       rst;
  logic [1:0]                 addr;
  logic [7:0]                 wdata;
  logic                       wr;
  logic                       rd;
  logic [7:0]                 rdata;
  logic                       pin_in;
  logic                       pin_read;
  logic                       pin_route;
  logic                       drive_off;
  logic                       ext_level;
  logic [7:0]                 vout;
  dacref_pkg::dacref_analog_t ana;
  int                         err_count;
  int                         comparisons;

  dacref_ctrl uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_digital_in(pin_in), .pin_digital_read(pin_read), .pin_analog_route(pin_route),
    .pin_digital_drive_off(drive_off), .analog_r(ana));
  dacref_ladder_model far (.clk(clk), .pin_route(pin_route), .ext_level(ext_level), .analog_r(ana),
    .pin_level(pin_in), .vout(vout));

  always #25 clk = ~clk;

  // ====
  // Access tasks
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask : rd_reg

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // ====
  // Tests
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ext_level = 1'b1;
    err_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("analog", {ana, pin_route, drive_off}, {dacref_pkg::ANALOG_RESET, 2'h0});
    rd_reg(dacref_pkg::ADDR_LEVEL, 8'h00);
    $display("test reset done");
    wr_reg(dacref_pkg::ADDR_CTRL0, 8'h80);
    for (int c = 0; c < 32; c++)
    begin
      wr_reg(dacref_pkg::ADDR_LEVEL, 8'(c));
      chk("tap", ana.tap_sel, 32'h1 << c);
      chk("vout", vout, 8'(c));
    end
    wr_reg(dacref_pkg::ADDR_CTRL0, 8'h00);
    chk("off", {ana.ladder_on, vout}, 9'h0FF);
    wr_reg(dacref_pkg::ADDR_CTRL0, 8'h40);
    chk("pos clamp", vout, 8'h20);
    wr_reg(dacref_pkg::ADDR_LEVEL, 8'h00);
    chk("no clamp", vout, 8'hFF);
    rd_reg(dacref_pkg::ADDR_STATUS, 8'h01);
    wr_reg(dacref_pkg::ADDR_CTRL0, 8'h00);
    chk("neg clamp", vout, 8'h00);
    rd_reg(dacref_pkg::ADDR_STATUS, 8'h02);
    $display("test ladder and clamps done");
    for (int p = 0; p < 4; p++)
    begin
      wr_reg(dacref_pkg::ADDR_CTRL0, 8'(8'h80 | (p << 2)));
      chk("pos sel", ana.pos_sel_onehot, (p == 3) ? 3'h0 : 3'(1 << p));
    end
    wr_reg(dacref_pkg::ADDR_CTRL0, 8'hFF);
    wr_reg(2'h3, 8'h00);
    wr_reg(dacref_pkg::ADDR_LEVEL, 8'hFF);
    rd_reg(dacref_pkg::ADDR_CTRL0, 8'hED);
    rd_reg(dacref_pkg::ADDR_LEVEL, 8'h1F);
    rd_reg(2'h3, 8'h00);
    $display("test register access done");
    wr_reg(dacref_pkg::ADDR_CTRL0, 8'h20);
    chk("route", {pin_route, drive_off}, 2'h3);
    repeat (20)
    begin
      @(posedge clk);
      #1;
      chk("pin read", pin_read, 1'b0);
    end
    rd_reg(dacref_pkg::ADDR_CTRL0, 8'h20);
    wr_reg(dacref_pkg::ADDR_CTRL0, 8'h00);
    @(posedge clk);
    #1;
    chk("pin read", pin_read, 1'b1);
    $display("test pin routing done");
    wr_reg(dacref_pkg::ADDR_CTRL0, 8'hA0);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset", {ana, pin_route, drive_off}, {dacref_pkg::ANALOG_RESET, 2'h0});
    rd_reg(dacref_pkg::ADDR_CTRL0, 8'h00);
    rd_reg(dacref_pkg::ADDR_LEVEL, 8'h00);
    $display("test mid-run reset done");
    stop_test();
  end

  // Whole run needs about 140 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule : dacref_ctrl_bench
